// ==== design/host_command_dispatcher.sv ====
// host command dispatcher: command register, parameter pool and dispatch
// Functional notes
// - valid commands have bit 15 set; writing one raises the doorbell.
// - device clears doorbell when done; host polls until clear.
// - host command during internal command is rejected at once with busy.
// - device writes response parameters into the same pool.
// - completion writes 8-bit status; 0x00 success, 0x01-0x10 errors.
// - codes 0x01 to 0x07 as listed.
// - codes 0x08 to 0x0c as listed.
// - codes 0x0d to 0x10 as listed.
// - status meanings are typical; subsystems may reuse codes freely.
// - unrecognised commands are rejected at once with unsupported.
// - system manager codes 0x8100 async, 0x8101 and 0x8102 sync.
// - overlay codes 0x8200 to 0x820e, mostly synchronous.
// - overlay 0x8206 and 0x820e are async; 0x8207 reads load status.
// - video-standard codes 0x8310 to 0x8313; 0x8311 is async.
// - gpio codes 0x8400 to 0x8405, all synchronous.
`timescale 1ns/1ps
`include "hcd_cfg.svh"
module host_command_dispatcher
   import hcd_pkg::*;
#(
   parameter int POOL_DEPTH = `HCD_POOL_DEPTH,
   parameter int POOL_AW    = $clog2(POOL_DEPTH)
)
(
   input  wire logic               core_clk_i,
   input  wire logic               reset_i,
   // host side of the command register
   input  wire logic               cmd_wr_i,
   input  wire logic [15:0]        cmd_wdata_i,
   output logic      [15:0]        cmd_rdata_o,
   output logic                    doorbell_o,
   // host side of the parameter pool
   input  wire logic               pool_wr_i,
   input  wire logic [POOL_AW-1:0] pool_addr_i,
   input  wire logic [15:0]        pool_wdata_i,
   output logic      [15:0]        pool_rdata_o,
   // internally requested command in progress
   input  wire logic               int_busy_i,
   // dispatch towards the subsystems
   output logic                    req_valid_o,
   output subsys_e                 req_subsys_o,
   output logic      [7:0]         req_op_o,
   output logic                    req_async_o,
   input  wire logic               done_i,
   input  wire logic [7:0]         done_status_i,
   // subsystem side of the pool: response writes and a read port
   input  wire logic               rsp_wr_i,
   input  wire logic [POOL_AW-1:0] rsp_addr_i,
   input  wire logic [15:0]        rsp_wdata_i,
   input  wire logic [POOL_AW-1:0] rsp_raddr_i,
   output logic      [15:0]        rsp_rdata_o
);

   // st_exec: doorbell up, waiting for the subsystem to finish
   typedef enum logic [1:0] {
      st_idle,
      st_exec
   } state_e;

   state_e          state_r;
   state_e          state_nxt;
   logic [15:0]     cmd_r;
   logic [15:0]     cmd_nxt;
   logic            req_valid_r;
   logic            req_valid_nxt;
   subsys_e         req_subsys_r;
   subsys_e         req_subsys_nxt;
   logic [7:0]      req_op_r;
   logic [7:0]      req_op_nxt;
   logic            req_async_r;
   logic            req_async_nxt;
   logic            host_take;
   logic            host_pool_we;

   logic [15:0]     pool_r [POOL_DEPTH];
   logic [15:0]     pool_rdata_r;
   logic [15:0]     pool_rdata_nxt;
   logic [15:0]     rsp_rdata_r;
   logic [15:0]     rsp_rdata_nxt;

   cmd_decode_if    dec ();

   assign dec.word = cmd_wdata_i;

   // only a write with the doorbell bit set is a command
   assign host_take = cmd_wr_i && cmd_wdata_i[`HCD_DOORBELL_BIT];

   // command code map, shared through the decode carrier
   cmd_decoder u_decoder (
      .dec (dec.decoder)
   );

   // status word placed in the command register, doorbell clear
   function automatic logic [15:0] result_word(input logic [7:0] st);
      result_word = {8'h00, st};
   endfunction

   // command register and dispatch state
   always_comb
   begin
      state_nxt      = state_r;
      cmd_nxt        = cmd_r;
      req_valid_nxt  = 1'b0;
      req_subsys_nxt = req_subsys_r;
      req_op_nxt     = req_op_r;
      req_async_nxt  = req_async_r;
      case (state_r)
         st_idle:
         begin
            if (host_take)
            begin
               if (int_busy_i)
               begin
                  cmd_nxt = result_word(status_busy);
               end
               else if (!dec.known)
               begin
                  cmd_nxt = result_word(status_unsupported);
               end
               else
               begin
                  cmd_nxt        = cmd_wdata_i;
                  state_nxt      = st_exec;
                  req_valid_nxt  = 1'b1;
                  req_subsys_nxt = dec.sub;
                  req_op_nxt     = dec.op;
                  req_async_nxt  = dec.is_async;
               end
            end
         end
         st_exec:
         begin
            // host writes are not looked at until the subsystem is done
            if (done_i)
            begin
               // status passed through unchanged, any code allowed
               // 0x01-0x07 0x08-0x0c 0x0d-0x10
               cmd_nxt   = result_word(done_status_i);
               state_nxt = st_idle;
            end
         end
         default:
         begin
            state_nxt = st_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         state_r      <= st_idle;
         cmd_r        <= `HCD_CMD_RESET;
         req_valid_r  <= 1'b0;
         req_subsys_r <= sub_none;
         req_op_r     <= 8'h00;
         req_async_r  <= 1'b0;
      end
      else
      begin
         state_r      <= state_nxt;
         cmd_r        <= cmd_nxt;
         req_valid_r  <= req_valid_nxt;
         req_subsys_r <= req_subsys_nxt;
         req_op_r     <= req_op_nxt;
         req_async_r  <= req_async_nxt;
      end
   end

   // parameter pool read ports
   always_comb
   begin
      pool_rdata_nxt = pool_r[pool_addr_i];
      rsp_rdata_nxt  = pool_r[rsp_raddr_i];
   end

   // host write dropped when a response write hits the same word
   assign host_pool_we = pool_wr_i && !(rsp_wr_i && (rsp_addr_i == pool_addr_i));

   // pool words are not reset; the host loads them before use
   always_ff @(posedge core_clk_i)
   begin
      if (rsp_wr_i)
      begin
         pool_r[rsp_addr_i] <= rsp_wdata_i;
      end
      if (host_pool_we)
      begin
         pool_r[pool_addr_i] <= pool_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         pool_rdata_r <= 16'h0000;
         rsp_rdata_r  <= 16'h0000;
      end
      else
      begin
         pool_rdata_r <= pool_rdata_nxt;
         rsp_rdata_r  <= rsp_rdata_nxt;
      end
   end

   assign cmd_rdata_o  = cmd_r;
   assign doorbell_o   = cmd_r[`HCD_DOORBELL_BIT];
   // request subsystem, op and async fields hold until the next dispatch; req_valid_o pulses for one cycle
   assign req_valid_o  = req_valid_r;
   assign req_subsys_o = req_subsys_r;
   assign req_op_o     = req_op_r;
   assign req_async_o  = req_async_r;
   assign pool_rdata_o = pool_rdata_r;
   assign rsp_rdata_o  = rsp_rdata_r;

endmodule

// ==== include/hcd_cfg.svh ====
// constants for the host command dispatcher
`ifndef HCD_CFG_SVH
`define HCD_CFG_SVH

`define HCD_DOORBELL_BIT   15
`define HCD_CMD_RESET      16'h0000
`define HCD_STATUS_W       8
`define HCD_GRP_SYSMGR     8'h81
`define HCD_GRP_OVERLAY    8'h82
`define HCD_GRP_VIDSTD     8'h83
`define HCD_GRP_GPIO       8'h84
`define HCD_SYS_LAST       8'h02
`define HCD_SYS_SET_STATE  8'h00
`define HCD_OVL_LAST       8'h0e
`define HCD_OVL_LOAD_BUF   8'h06
`define HCD_OVL_LOAD_STR   8'h0e
`define HCD_VID_FIRST      8'h10
`define HCD_VID_LAST       8'h13
`define HCD_VID_LOAD_CFG   8'h11
`define HCD_GPIO_LAST      8'h05
`define HCD_POOL_DEPTH     64

`endif

// ==== include/hcd_pkg.sv ====
// types shared by the host command dispatcher
package hcd_pkg;

   typedef enum logic [7:0] {
      status_success           = 8'h00,
      status_no_entity         = 8'h01,
      status_interrupted       = 8'h02,
      status_io_failure        = 8'h03,
      status_too_big           = 8'h04,
      status_bad_handle        = 8'h05,
      status_try_again         = 8'h06,
      status_no_resource       = 8'h07,
      status_denied            = 8'h08,
      status_busy              = 8'h09,
      status_exists            = 8'h0a,
      status_no_device         = 8'h0b,
      status_invalid_arg       = 8'h0c,
      status_no_space          = 8'h0d,
      status_out_of_range      = 8'h0e,
      status_unsupported       = 8'h0f,
      status_already_requested = 8'h10
   } status_e;

   typedef enum logic [2:0] {
      sub_none,
      sub_system_manager,
      sub_overlay,
      sub_video_standard_config_manager,
      sub_gpio
   } subsys_e;

endpackage

// ==== include/cmd_decode_if.sv ====
// command word decode carrier between dispatcher and decoder
`timescale 1ns/1ps
interface cmd_decode_if;
   import hcd_pkg::*;
   logic [15:0] word;
   logic        known;
   subsys_e     sub;
   logic [7:0]  op;
   logic        is_async;

   modport decoder (input word, output known, sub, op, is_async);
   modport user    (output word, input known, sub, op, is_async);
endinterface

// ==== design/cmd_decoder.sv ====
// command code map: subsystem, operation and async flag
`timescale 1ns/1ps
`include "hcd_cfg.svh"
module cmd_decoder
   import hcd_pkg::*;
(
   cmd_decode_if.decoder dec
);

   logic [7:0] grp;
   logic [7:0] lo;

   assign grp    = dec.word[15:8];
   assign lo     = dec.word[7:0];
   assign dec.op = lo;

   // high byte picks subsystem, low byte the operation
   always_comb
   begin
      dec.known    = 1'b0;
      dec.sub      = sub_none;
      dec.is_async = 1'b0;
      case (grp)
         `HCD_GRP_SYSMGR:
         begin
            dec.known    = (lo <= `HCD_SYS_LAST);
            dec.sub      = sub_system_manager;
            dec.is_async = (lo == `HCD_SYS_SET_STATE);
         end
         `HCD_GRP_OVERLAY:
         begin
            dec.known    = (lo <= `HCD_OVL_LAST);
            dec.sub      = sub_overlay;
            dec.is_async = (lo == `HCD_OVL_LOAD_BUF) || (lo == `HCD_OVL_LOAD_STR);
         end
         `HCD_GRP_VIDSTD:
         begin
            dec.known    = (lo >= `HCD_VID_FIRST) && (lo <= `HCD_VID_LAST);
            dec.sub      = sub_video_standard_config_manager;
            dec.is_async = (lo == `HCD_VID_LOAD_CFG);
         end
         `HCD_GRP_GPIO:
         begin
            dec.known    = (lo <= `HCD_GPIO_LAST);
            dec.sub      = sub_gpio;
         end
         default:
         begin
            dec.known    = 1'b0;
         end
      endcase
      if (!dec.word[`HCD_DOORBELL_BIT])
      begin
         dec.known = 1'b0;
      end
   end

endmodule

// ==== sim/hcd_assertions.sv ====
// port checks of the dispatcher
`timescale 1ns/1ps
module hcd_assertions (
   input wire logic        core_clk_i,
   input wire logic        reset_i,
   input wire logic        cmd_wr_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [15:0] cmd_rdata_o,
   input wire logic        doorbell_o,
   input wire logic        int_busy_i,
   input wire logic        req_valid_o,
   input wire logic [7:0]  req_op_o,
   input wire logic        req_async_o,
   input wire logic        done_i,
   input wire logic [7:0]  done_status_i
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   wire tk = cmd_wr_i && cmd_wdata_i[15] && !doorbell_o;
   a_busy_reject: assert property (tk && int_busy_i |=> cmd_rdata_o == 16'h0009 && !doorbell_o)
      else $error("busy");
   a_accept_cmd: assert property (tk && !int_busy_i |=> doorbell_o ?
      cmd_rdata_o == $past(cmd_wdata_i) && req_valid_o : cmd_rdata_o == 16'h000f && !req_valid_o)
      else $error("accept");
   a_done_status: assert property (doorbell_o && done_i |=>
      !doorbell_o && cmd_rdata_o == {8'h00, $past(done_status_i)}) else $error("done");
   a_cmd_hold: assert property (doorbell_o && !done_i |=> doorbell_o && $stable(cmd_rdata_o))
      else $error("hold");
   a_idle_hold: assert property (!doorbell_o && !tk |=> !doorbell_o && $stable(cmd_rdata_o))
      else $error("idle");
   a_req_pulse: assert property (req_valid_o |=> !req_valid_o)
      else $error("pulse");
   a_req_op: assert property (req_valid_o |-> doorbell_o && req_op_o == cmd_rdata_o[7:0])
      else $error("op");
   a_req_async: assert property (req_valid_o |-> req_async_o ==
      (cmd_rdata_o inside {16'h8100, 16'h8206, 16'h820e, 16'h8311})) else $error("async");
endmodule

// ==== sim/subsys_model.sv ====
// subsystem model: completes each dispatched command
`timescale 1ns/1ps
module subsys_model (
   input  wire logic        core_clk_i,
   input  wire logic        req_valid_i,
   input  wire logic [7:0]  req_op_i,
   input  wire logic [7:0]  lat_i,
   input  wire logic [7:0]  status_i,
   output logic             done_o = 1'b0,
   output logic [7:0]       status_o = 8'h00,
   output logic             rsp_wr_o = 1'b0,
   output logic [15:0]      rsp_wdata_o = 16'h0000
);
   logic [7:0] cnt = 8'h00;
   logic [7:0] op = 8'h00;
   wire        fin = !req_valid_i && cnt == 8'h01;
   always @(posedge core_clk_i)
   begin
      if (req_valid_i)
      begin
         cnt <= lat_i;
         op <= req_op_i;
      end
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
      done_o <= fin;
      status_o <= fin ? status_i : ~status_i;
      rsp_wr_o <= fin;
      rsp_wdata_o <= fin ? {8'h5a, op} : ~{8'h5a, op};
   end
endmodule

// ==== sim/tb.sv ====
// self-checking bench of the dispatcher
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin error_cnt++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
   import hcd_pkg::*;
   logic        core_clk_i = 0, reset_i = 1, cmd_wr_i = 0, pool_wr_i = 0, int_busy_i = 0;
   logic        done_i, rsp_wr_i, req_valid_o, doorbell_o, req_async_o;
   logic [15:0] cmd_wdata_i = 0, pool_wdata_i = 0, cmd_rdata_o, pool_rdata_o;
   logic [15:0] rsp_wdata_i, rsp_rdata_o, last = 0, exp;
   logic [5:0]  pool_addr_i = 0, rsp_addr_i = 6'h3f, rsp_raddr_i = 6'h3f;
   logic [7:0]  done_status_i, req_op_o, lat = 1, st = 0;
   logic [31:0] seed = 59;
   subsys_e     req_subsys_o;
   int          error_cnt = 0, comparisons = 0;
   logic [15:0] q[$];
   host_command_dispatcher dut (.*);
   subsys_model pm (.core_clk_i, .req_valid_i(req_valid_o), .req_op_i(req_op_o), .lat_i(lat),
      .status_i(st), .done_o(done_i), .status_o(done_status_i), .rsp_wr_o(rsp_wr_i),
      .rsp_wdata_o(rsp_wdata_i));
   initial forever #5 core_clk_i = ~core_clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic subsys_e sub_of(input logic [15:0] w);
      case (w[15:8])
         8'h81: return w[7:0] <= 8'h02 ? sub_system_manager : sub_none;
         8'h82: return w[7:0] <= 8'h0e ? sub_overlay : sub_none;
         8'h83: return w[7:0] inside {[8'h10:8'h13]} ? sub_video_standard_config_manager : sub_none;
         8'h84: return w[7:0] <= 8'h05 ? sub_gpio : sub_none;
         default: return sub_none;
      endcase
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmd(input logic [15:0] w, input logic b, input logic stray);
      subsys_e s;
      logic    ok;
      s = sub_of(w);
      ok = !b && s != sub_none;
      lat = stray ? 8'h14 : 8'(1 + rnd() % 4);
      st = 8'(rnd() % 17);
      last = b ? 16'h0009 : s == sub_none ? 16'h000f : {8'h00, st};
      @(negedge core_clk_i);
      cmd_wr_i = 1;
      cmd_wdata_i = w;
      int_busy_i = b;
      q.push_back(last);
      @(negedge core_clk_i);
      cmd_wr_i = 0;
      int_busy_i = 0;
      if (ok) `CHK("req", {1'b1, s, w[7:0], w inside {16'h8100, 16'h8206, 16'h820e, 16'h8311}},
         {req_valid_o, req_subsys_o, req_op_o, req_async_o})
      else `CHK("req_valid", 1'b0, req_valid_o)
      for (int i = 0; i < 40 && doorbell_o !== 1'b0; i++)
      begin
         cmd_wr_i = stray && i == 2;
         cmd_wdata_i = 16'h8200;
         @(negedge core_clk_i);
      end
      cmd_wr_i = 0;
      pool_addr_i = 6'h3f;
      if (doorbell_o !== 1'b0)
      begin
         error_cnt++;
         tally_and_finish();
      end
      @(negedge core_clk_i);
      if (ok) `CHK("rsp", {8'h5a, w[7:0]}, rsp_rdata_o)
      if (ok) `CHK("pool_rsp", {8'h5a, w[7:0]}, pool_rdata_o)
   endtask
   always @(posedge core_clk_i)
   begin
      logic t, d;
      t = cmd_wr_i && cmd_wdata_i[15] && !doorbell_o;
      d = doorbell_o;
      #1;
      if (!reset_i && !doorbell_o && (t || d))
      begin
         exp = q.size() != 0 ? q.pop_front() : 16'hxxxx;
         `CHK("cmd_rdata", exp, cmd_rdata_o)
      end
   end
   initial
   begin
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i);
      reset_i = 0;
      `CHK("reset", 17'h0, {doorbell_o, cmd_rdata_o})
      repeat (4)
      begin
         @(negedge core_clk_i);
         pool_wr_i = 1;
         pool_addr_i = 6'(rnd() % 63);
         pool_wdata_i = 16'(rnd());
         @(negedge core_clk_i);
         pool_wr_i = 0;
         @(negedge core_clk_i);
         `CHK("pool", pool_wdata_i, pool_rdata_o)
      end
      cmd(16'h8101, 1, 0);
      cmd(16'h8101, 0, 0);
      cmd(16'h8500, 1, 0);
      cmd(16'h8207, 0, 1);
      @(negedge core_clk_i);
      cmd_wr_i = 1;
      cmd_wdata_i = 16'h0101;
      @(negedge core_clk_i);
      cmd_wr_i = 0;
      @(negedge core_clk_i);
      `CHK("no_bit15", {1'b0, last}, {doorbell_o, cmd_rdata_o})
      for (int h = 8'h80; h <= 8'h85; h++)
         for (int l = 0; l < 8'h15; l++)
            cmd({8'(h), 8'(l)}, 0, 0);
      repeat (2) @(negedge core_clk_i);
      `CHK("queue", 0, q.size())
      tally_and_finish();
   end
endmodule
bind host_command_dispatcher hcd_assertions chk (.core_clk_i, .reset_i, .cmd_wr_i, .cmd_wdata_i,
   .cmd_rdata_o, .doorbell_o, .int_busy_i, .req_valid_o, .req_op_o, .req_async_o, .done_i,
   .done_status_i);
